// ---- hw/fcd_pkg.sv ----
// Package: register map, field layout, encodings and types of the cosh / loop-branch decoder
package fcd_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_WORD1 = 8'h04;
  localparam logic [7:0] OFS_WORD2 = 8'h08;
  localparam logic [7:0] OFS_DISP = 8'h0C;
  localparam logic [7:0] OFS_IADDR = 8'h10;
  localparam logic [7:0] OFS_COUNT = 8'h14;
  localparam logic [7:0] OFS_FPSR = 8'h18;
  localparam logic [7:0] OFS_SRC = 8'h1C;
  localparam logic [7:0] OFS_RESULT = 8'h20;
  localparam logic [7:0] OFS_NPC = 8'h24;
  localparam logic [7:0] OFS_DSTAT = 8'h28;
  // Control bits and reset values
  localparam int CTRL_GO = 0;
  localparam int CTRL_TRAP_EN = 1;
  localparam logic [31:0] CTRL_RST = 32'h0000_0002;
  localparam logic [31:0] FPSR_RST = 32'h0000_0000;
  // Exception byte, accrued byte and condition code bit positions
  localparam int EXC_UNORDERED_BRANCH_FLAG = 7;
  localparam int EXC_SIGNALING_NAN_FLAG = 6;
  localparam int EXC_OPERAND_ERROR_FLAG = 5;
  localparam int EXC_OVERFLOW_FLAG = 4;
  localparam int EXC_UNDERFLOW_FLAG = 3;
  localparam int EXC_DZ = 2;
  localparam int EXC_RESULT_INEXACT_FLAG = 1;
  localparam int EXC_DECIMAL_INPUT_INEXACT_FLAG = 0;
  localparam int ACC_IOP = 7;
  localparam int CC_N = 3;
  localparam int CC_Z = 2;
  localparam int CC_I = 1;
  localparam int CC_NAN = 0;
  // Source operand descriptor fields
  localparam int SRC_SIGN = 4;
  localparam int SRC_PK_INEX = 8;
  localparam logic [1:0] CLS_NORM = 2'h0;
  localparam logic [1:0] CLS_ZERO = 2'h1;
  localparam logic [1:0] CLS_INF = 2'h2;
  localparam logic [1:0] CLS_NAN = 2'h3;
  // Instruction encodings
  localparam logic [3:0] LINE_F = 4'hF;
  localparam logic [2:0] GRP_GEN = 3'h0;
  localparam logic [2:0] GRP_LOOP = 3'h1;
  localparam logic [6:0] OPM_COSH = 7'h1D;
  localparam logic [2:0] MODE_DREG = 3'h0;
  localparam logic [2:0] MODE_AREG = 3'h1;
  localparam logic [2:0] MODE_EXT = 3'h7;
  localparam logic [2:0] EXT_MAX = 3'h4;
  localparam logic [2:0] FMT_L = 3'h0;
  localparam logic [2:0] FMT_S = 3'h1;
  localparam logic [2:0] FMT_P = 3'h3;
  localparam logic [2:0] FMT_W = 3'h4;
  localparam logic [2:0] FMT_B = 3'h6;
  localparam logic [2:0] FMT_BAD = 3'h7;
  // Result kinds
  localparam logic [1:0] RES_CALC = 2'h0;
  localparam logic [1:0] RES_ONE = 2'h1;
  localparam logic [1:0] RES_INF = 2'h2;
  localparam logic [1:0] RES_NAN = 2'h3;
  // Program counter offsets in bytes, counter end value and bus response codes
  localparam logic [31:0] SEQ_LEN = 32'h0000_0006;
  localparam logic [31:0] DISP_BASE = 32'h0000_0002;
  localparam logic [15:0] CNT_EXHAUSTED = 16'hFFFF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [7:0] cc;
    logic [7:0] quot;
    logic [7:0] exc;
    logic [7:0] acc;
  } fcd_fpsr_t;

  typedef struct packed {
    logic mine;
    logic is_cosh;
    logic is_loop;
  } fcd_dec_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_DEC = 3'b010,
    ST_EXE = 3'b100
  } fcd_state_t;
endpackage

// ---- hw/fcd_decoder.sv ----
// Cosh and loop-branch coprocessor decoder with AXI4-Lite register access
module fcd_decoder
  import fcd_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter logic [2:0] CPID = 3'h1
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic pre_exc_req
);
  import fcd_pkg::*;

  // Refuse address widths that cannot reach the whole register map
  if (ADDR_W < 6 || ADDR_W > 8)
  begin
    $error("ADDR_W must be 6 to 8");
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[i*8 +: 8] = dat[i*8 +: 8];
    return r;
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    return a[ADDR_W-1:2] == ofs[ADDR_W-1:2];
  endfunction

  // Sixteen base tests, bit 4 only changes NaN awareness
  function automatic logic pred_true(input logic [3:0] p, input logic [7:0] cc);
    logic n;
    logic z;
    logic u;
    n = cc[CC_N];
    z = cc[CC_Z];
    u = cc[CC_NAN];
    case (p)
      4'h0: return 1'b0;
      4'h1: return z;
      4'h2: return !(u || z || n);
      4'h3: return z || !(u || n);
      4'h4: return n && !(u || z);
      4'h5: return z || (n && !u);
      4'h6: return !(u || z);
      4'h7: return !u;
      4'h8: return u;
      4'h9: return u || z;
      4'hA: return u || !(n || z);
      4'hB: return u || z || !n;
      4'hC: return u || (n && !z);
      4'hD: return u || z || n;
      4'hE: return !z;
      default: return 1'b1;
    endcase
  endfunction

  fcd_state_t st_q, st_d;
  fcd_dec_t dec_q, dec_d;
  fcd_fpsr_t fpsr_q, fpsr_d;
  logic [31:0] ctrl_q, iaddr_q, count_q, count_d, src_q, npc_q, npc_d;
  logic [15:0] w1_q, w2_q, disp_q;
  logic [7:0] res_q, res_d;
  logic [3:0] dstat_q, dstat_d;
  logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q, exc_q, exc_d;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q, rd_mux;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;

  // Bus handshakes
  wire aw_take = awvalid && awready;
  wire w_take = wvalid && wready;
  wire wr_go = aw_hold_q && w_hold_q;
  wire ar_take = arvalid && arready;
  assign awready = !aw_hold_q && !bvalid_q;
  assign wready = !w_hold_q && !bvalid_q;
  assign arready = !rvalid_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign pre_exc_req = exc_q;

  wire wr_ctrl = wr_go && hit(awaddr_q, OFS_CTRL);
  wire wr_w1 = wr_go && hit(awaddr_q, OFS_WORD1);
  wire wr_w2 = wr_go && hit(awaddr_q, OFS_WORD2);
  wire wr_disp = wr_go && hit(awaddr_q, OFS_DISP);
  wire wr_iaddr = wr_go && hit(awaddr_q, OFS_IADDR);
  wire wr_count = wr_go && hit(awaddr_q, OFS_COUNT);
  wire wr_fpsr = wr_go && hit(awaddr_q, OFS_FPSR);
  wire wr_src = wr_go && hit(awaddr_q, OFS_SRC);
  wire wr_ro = wr_go && (hit(awaddr_q, OFS_RESULT) || hit(awaddr_q, OFS_NPC)
                         || hit(awaddr_q, OFS_DSTAT));
  wire wr_map = wr_ctrl || wr_w1 || wr_w2 || wr_disp || wr_iaddr || wr_count || wr_fpsr
                || wr_src || wr_ro;
  wire [31:0] wr_val = merge(32'h0000_0000, wdata_q, wstrb_q);
  wire go = wr_ctrl && wstrb_q[0] && wdata_q[CTRL_GO] && st_q == ST_IDLE;
  wire trap_en = ctrl_q[CTRL_TRAP_EN];

  // Instruction fields
  wire [2:0] grp = w1_q[8:6];
  wire [2:0] ea_mode = w1_q[5:3];
  wire [2:0] ea_reg = w1_q[2:0];
  wire rm = w2_q[14];
  wire [2:0] spec = w2_q[12:10];
  wire [2:0] dst = w2_q[9:7];
  wire [6:0] opm = w2_q[6:0];
  wire [5:0] pred = w2_q[5:0];
  wire mine = w1_q[15:12] == LINE_F && w1_q[11:9] == CPID;
  wire fmt_small = spec == FMT_B || spec == FMT_W || spec == FMT_L || spec == FMT_S;
  wire ea_dreg = ea_mode == MODE_DREG && fmt_small;
  wire ea_mem = ea_mode != MODE_DREG && ea_mode != MODE_AREG && ea_mode != MODE_EXT;
  wire ea_ext = ea_mode == MODE_EXT && ea_reg <= EXT_MAX;
  wire ea_ok = ea_dreg || ea_mem || ea_ext;
  // Register source needs no address field; memory source needs a format and a mode
  wire src_ok = !rm || (spec != FMT_BAD && ea_ok);
  wire cosh_enc = grp == GRP_GEN && !w2_q[15] && !w2_q[13] && opm == OPM_COSH && src_ok;
  wire loop_enc = grp == GRP_LOOP && w2_q[15:6] == 10'h000 && !pred[5];

  always_comb
  begin
    dec_d.mine = mine;
    dec_d.is_cosh = mine && cosh_enc;
    dec_d.is_loop = mine && loop_enc;
  end

  // Execution
  wire [1:0] cls = src_q[1:0];
  wire packed_src = rm && spec == FMT_P;
  wire cond = pred_true(pred[3:0], fpsr_q.cc);
  wire unord = fpsr_q.cc[CC_NAN] && pred[4];
  wire trap = unord && trap_en;
  wire [15:0] cnt_dec = count_q[15:0] - 16'h0001;
  wire [31:0] seq_pc = iaddr_q + SEQ_LEN;
  wire [31:0] br_pc = iaddr_q + DISP_BASE + {{16{disp_q[15]}}, disp_q};
  wire exe = st_q == ST_EXE;

  always_comb
  begin
    fpsr_d = wr_fpsr ? fcd_fpsr_t'(merge(fpsr_q, wdata_q, wstrb_q)) : fpsr_q;
    count_d = wr_count ? merge(count_q, wdata_q, wstrb_q) : count_q;
    npc_d = npc_q;
    res_d = res_q;
    dstat_d = dstat_q;
    exc_d = 1'b0;
    if (exe)
    begin
      // Status: branch taken, trapped, foreign, illegal
      dstat_d = {1'b0, 1'b0, !dec_q.mine, dec_q.mine && !dec_q.is_cosh && !dec_q.is_loop};
      if (dec_q.is_cosh)
      begin
        res_d = {1'b1, dst, 2'h0, RES_CALC};
        if (cls == CLS_ZERO)
          res_d[1:0] = RES_ONE;
        else if (cls == CLS_INF)
          res_d[1:0] = RES_INF;
        else if (cls == CLS_NAN)
          res_d[1:0] = RES_NAN;
        fpsr_d.cc = 8'h00;
        fpsr_d.cc[CC_I] = cls == CLS_INF;
        fpsr_d.cc[CC_NAN] = cls == CLS_NAN;
        fpsr_d.exc = 8'h00;
        fpsr_d.exc[EXC_DECIMAL_INPUT_INEXACT_FLAG] = packed_src && src_q[SRC_PK_INEX];
      end
      else if (dec_q.is_loop)
      begin
        fpsr_d.exc[EXC_UNORDERED_BRANCH_FLAG] = unord;
        if (unord)
          fpsr_d.acc[ACC_IOP] = 1'b1;
        if (trap)
        begin
          exc_d = 1'b1;
          npc_d = iaddr_q;
          dstat_d[2] = 1'b1;
        end
        else if (cond)
          npc_d = seq_pc;
        else
        begin
          count_d = {count_q[31:16], cnt_dec};
          npc_d = cnt_dec == CNT_EXHAUSTED ? seq_pc : br_pc;
          dstat_d[3] = cnt_dec != CNT_EXHAUSTED;
        end
      end
    end
  end

  always_comb
  begin
    case (st_q)
      ST_IDLE: st_d = go ? ST_DEC : ST_IDLE;
      ST_DEC: st_d = ST_EXE;
      ST_EXE: st_d = ST_IDLE;
      default: st_d = ST_IDLE;
    endcase
  end

  assign rd_mux = hit(araddr, OFS_CTRL) ? ctrl_q :
                  hit(araddr, OFS_WORD1) ? {16'h0000, w1_q} :
                  hit(araddr, OFS_WORD2) ? {16'h0000, w2_q} :
                  hit(araddr, OFS_DISP) ? {16'h0000, disp_q} :
                  hit(araddr, OFS_IADDR) ? iaddr_q :
                  hit(araddr, OFS_COUNT) ? count_q :
                  hit(araddr, OFS_FPSR) ? fpsr_q :
                  hit(araddr, OFS_SRC) ? src_q :
                  hit(araddr, OFS_RESULT) ? {24'h000000, res_q} :
                  hit(araddr, OFS_NPC) ? npc_q :
                  hit(araddr, OFS_DSTAT) ? {27'h0000000, dstat_q, st_q != ST_IDLE} :
                  32'h0000_0000;
  wire rd_map = hit(araddr, OFS_CTRL) || hit(araddr, OFS_WORD1) || hit(araddr, OFS_WORD2)
                || hit(araddr, OFS_DISP) || hit(araddr, OFS_IADDR) || hit(araddr, OFS_COUNT)
                || hit(araddr, OFS_FPSR) || hit(araddr, OFS_SRC) || hit(araddr, OFS_RESULT)
                || hit(araddr, OFS_NPC) || hit(araddr, OFS_DSTAT);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      bvalid_q <= 1'b0;
      rvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      awaddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end
    else
    begin
      aw_hold_q <= aw_take || (aw_hold_q && !wr_go);
      w_hold_q <= w_take || (w_hold_q && !wr_go);
      if (aw_take)
        awaddr_q <= awaddr;
      if (w_take)
      begin
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (wr_go)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bready)
        bvalid_q <= 1'b0;
      if (ar_take)
      begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_mux;
        rresp_q <= rd_map ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rready)
        rvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q <= ST_IDLE;
      dec_q <= '0;
      ctrl_q <= CTRL_RST;
      w1_q <= 16'h0000;
      w2_q <= 16'h0000;
      disp_q <= 16'h0000;
      iaddr_q <= 32'h0000_0000;
      src_q <= 32'h0000_0000;
      count_q <= 32'h0000_0000;
      fpsr_q <= FPSR_RST;
      npc_q <= 32'h0000_0000;
      res_q <= 8'h00;
      dstat_q <= 4'h0;
      exc_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      if (st_q == ST_DEC)
        dec_q <= dec_d;
      if (wr_ctrl)
        ctrl_q <= {wr_val[31:1], 1'b0};
      if (wr_w1 && st_q == ST_IDLE)
        w1_q <= wr_val[15:0];
      if (wr_w2 && st_q == ST_IDLE)
        w2_q <= wr_val[15:0];
      if (wr_disp && st_q == ST_IDLE)
        disp_q <= wr_val[15:0];
      if (wr_iaddr && st_q == ST_IDLE)
        iaddr_q <= merge(iaddr_q, wdata_q, wstrb_q);
      if (wr_src && st_q == ST_IDLE)
        src_q <= merge(src_q, wdata_q, wstrb_q);
      count_q <= count_d;
      fpsr_q <= fpsr_d;
      npc_q <= npc_d;
      res_q <= res_d;
      dstat_q <= dstat_d;
      exc_q <= exc_d;
    end
  end

  // Checks
  wire x_cosh = exe && dec_q.is_cosh;
  wire x_loop = exe && dec_q.is_loop;

  AST_WR_ANSWER: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go |=> bvalid && !awready && !wready)
    else $error("write answer missing");
  AST_RD_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data not held");
  AST_AREG_ILLEGAL: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q == ST_DEC && rm && ea_mode == MODE_AREG |=> !dec_q.is_cosh)
    else $error("address register source accepted");
  AST_COSH_SPECIAL: assert property (@(posedge aclk) disable iff (!aresetn)
    x_cosh && cls == CLS_ZERO |=> res_q[1:0] == RES_ONE && res_q[7])
    else $error("cosh of zero not one");
  AST_COSH_INF: assert property (@(posedge aclk) disable iff (!aresetn)
    x_cosh && cls == CLS_INF |=> res_q[1:0] == RES_INF && fpsr_q.cc[CC_I])
    else $error("cosh of infinity not infinity");
  AST_COSH_FLAGS: assert property (@(posedge aclk) disable iff (!aresetn)
    x_cosh && !wr_fpsr |=> fpsr_q.quot == $past(fpsr_q.quot) && !fpsr_q.exc[EXC_UNORDERED_BRANCH_FLAG]
      && !fpsr_q.exc[EXC_OPERAND_ERROR_FLAG] && !fpsr_q.exc[EXC_UNDERFLOW_FLAG] && !fpsr_q.exc[EXC_DZ])
    else $error("cosh flag update wrong");
  AST_COSH_DECIMAL_INPUT_INEXACT_FLAG: assert property (@(posedge aclk) disable iff (!aresetn)
    x_cosh && !packed_src |=> !fpsr_q.exc[EXC_DECIMAL_INPUT_INEXACT_FLAG])
    else $error("decimal inexact set for non-packed source");
  AST_LOOP_TRUE: assert property (@(posedge aclk) disable iff (!aresetn)
    x_loop && cond && !trap && !wr_count |=> count_q == $past(count_q)
      && npc_q == $past(iaddr_q) + SEQ_LEN)
    else $error("true condition did not fall through");
  AST_LOOP_DEC: assert property (@(posedge aclk) disable iff (!aresetn)
    x_loop && !cond && !trap |=> count_q[15:0] == $past(count_q[15:0]) - 16'h0001
      && npc_q == ($past(count_q[15:0]) == 16'h0000 ? $past(iaddr_q) + SEQ_LEN : $past(br_pc)))
    else $error("counter or branch target wrong");
  AST_LOOP_IOP: assert property (@(posedge aclk) disable iff (!aresetn)
    x_loop && unord |=> fpsr_q.acc[ACC_IOP] && fpsr_q.exc[EXC_UNORDERED_BRANCH_FLAG])
    else $error("unordered branch not accrued");
  AST_TRAP: assert property (@(posedge aclk) disable iff (!aresetn)
    x_loop && trap && !wr_count |=> pre_exc_req && count_q == $past(count_q) ##1 !pre_exc_req)
    else $error("trap not raised or loop completed");

  CV_COSH: cover property (@(posedge aclk) disable iff (!aresetn) x_cosh);
  CV_BRANCH: cover property (@(posedge aclk) disable iff (!aresetn)
    x_loop && !cond && !trap && cnt_dec != CNT_EXHAUSTED);
  CV_EXHAUST: cover property (@(posedge aclk) disable iff (!aresetn)
    x_loop && !cond && !trap && cnt_dec == CNT_EXHAUSTED);
  CV_TRAP: cover property (@(posedge aclk) disable iff (!aresetn) x_loop && trap);
endmodule

// ---- bench/fcd_host_model.sv ----
// Main processor stand-in that takes pre-instruction exception requests
module fcd_host_model
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pre_exc_req,
  output int trap_count
);
  timeunit 1ns;
  timeprecision 100ps;
  // Each request pulse is one exception taken before the loop branch completes
  always @(posedge aclk)
  begin
    if (!aresetn)
      trap_count <= 0;
    else if (pre_exc_req === 1'b1)
      trap_count <= trap_count + 1;
  end
endmodule

// ---- bench/fcd_decoder_bench.sv ----
// Self-checking bench for the cosh and loop-branch decoder
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, (g), (e)); end end

module fcd_decoder_bench;
  import fcd_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic wvalid = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hF;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic rready = 1'b0;
  logic awready;
  logic wready;
  logic bvalid;
  logic [1:0] bresp;
  logic arready;
  logic rvalid;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic pre_exc_req;
  int traps;
  int miscompares = 0;
  int num_checks = 0;

  always #50 aclk = ~aclk;

  fcd_decoder uut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .pre_exc_req(pre_exc_req));

  fcd_host_model host (.aclk(aclk), .aresetn(aresetn), .pre_exc_req(pre_exc_req),
    .trap_count(traps));

  task automatic close_out;
    begin
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask

  task automatic timed_out;
    begin
      miscompares++;
      $display("MISMATCH t=%0t wait ran out", $time);
      close_out();
    end
  endtask

  // Write one word, both channels offered together, response checked
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic ad;
    logic wd;
    begin
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wvalid <= 1'b1;
      bready <= 1'b1;
      ad = 1'b0;
      wd = 1'b0;
      n = 0;
      while (!(ad && wd))
      begin
        @(posedge aclk);
        if (!ad && awready === 1'b1)
        begin
          ad = 1'b1;
          awvalid <= 1'b0;
        end
        if (!wd && wready === 1'b1)
        begin
          wd = 1'b1;
          wvalid <= 1'b0;
        end
        n++;
        if (n > 50)
          timed_out();
      end
      do
      begin
        @(posedge aclk);
        n++;
        if (n > 100)
          timed_out();
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      `CHK(bresp, er)
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    begin
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      do
      begin
        @(posedge aclk);
        n++;
        if (n > 50)
          timed_out();
      end while (arready !== 1'b1);
      arvalid <= 1'b0;
      do
      begin
        @(posedge aclk);
        n++;
        if (n > 100)
          timed_out();
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    begin
      rd(a, d, r);
      `CHK(r, RESP_OKAY)
      `CHK(d, e)
    end
  endtask

  // Load an instruction, start it and wait until the unit is idle again
  task automatic run(input logic [31:0] w1, w2, src, fp, cnt, ctl);
    logic [31:0] d;
    logic [1:0] r;
    int n;
    begin
      wr(OFS_WORD1, w1, RESP_OKAY);
      wr(OFS_WORD2, w2, RESP_OKAY);
      wr(OFS_SRC, src, RESP_OKAY);
      wr(OFS_FPSR, fp, RESP_OKAY);
      wr(OFS_COUNT, cnt, RESP_OKAY);
      wr(OFS_CTRL, ctl, RESP_OKAY);
      n = 0;
      d = 32'h0000_0001;
      while (d[0] !== 1'b0)
      begin
        rd(OFS_DSTAT, d, r);
        n++;
        if (n > 20)
          timed_out();
      end
    end
  endtask

  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    begin
      rchk(OFS_CTRL, CTRL_RST);
      rchk(OFS_FPSR, FPSR_RST);
      rchk(OFS_COUNT, 32'h0000_0000);
      rd(8'hFC, d, r);
      `CHK(r, RESP_SLVERR)
      `CHK(d, 32'h0000_0000)
      wr(8'hFC, 32'h1234_5678, RESP_SLVERR);
      wr(OFS_RESULT, 32'hFFFF_FFFF, RESP_OKAY);
      rchk(OFS_RESULT, 32'h0000_0000);
      $display("test reset done");
    end
  endtask

  task automatic t_cosh;
    begin
      run(32'h0000_F23F, 32'h0000_059D, 32'h0000_0011, 32'h005A_FF00, 32'h0, 32'h3);
      rchk(OFS_RESULT, 32'h0000_00B1);
      rchk(OFS_FPSR, 32'h005A_0000);
      run(32'h0000_F210, 32'h0000_4D1D, 32'h0000_0112, 32'h005A_FF80, 32'h0, 32'h3);
      rchk(OFS_RESULT, 32'h0000_00A2);
      rchk(OFS_FPSR, 32'h025A_0180);
      $display("test cosh done");
    end
  endtask

  task automatic t_refuse;
    logic [31:0] w1s [6] = '{32'hF208, 32'hF200, 32'hF23D, 32'hF400, 32'hF241, 32'hF200};
    logic [31:0] w2s [6] = '{32'h419D, 32'h499D, 32'h419D, 32'h059D, 32'h0040, 32'h441D};
    logic [31:0] exs [6] = '{32'h2, 32'h2, 32'h2, 32'h4, 32'h2, 32'h0};
    logic [31:0] d;
    logic [1:0] r;
    begin
      for (int i = 0; i < 6; i++)
      begin
        run(w1s[i], w2s[i], 32'h0000_0001, 32'h0, 32'h5, 32'h3);
        rd(OFS_DSTAT, d, r);
        `CHK(d & 32'h6, exs[i])
      end
      rchk(OFS_RESULT, 32'h0000_0081);
      $display("test refuse done");
    end
  endtask

  task automatic t_loop;
    logic [31:0] d;
    logic [1:0] r;
    begin
      wr(OFS_DISP, 32'h0000_FFF0, RESP_OKAY);
      wr(OFS_IADDR, 32'h0000_1000, RESP_OKAY);
      run(32'hF241, 32'h000F, 32'h0, 32'h0E5A_3C11, 32'h0003_0005, 32'h3);
      rchk(OFS_NPC, 32'h0000_1006);
      rchk(OFS_COUNT, 32'h0003_0005);
      run(32'hF241, 32'h0000, 32'h0, 32'h0E5A_3C11, 32'h0003_0005, 32'h3);
      rchk(OFS_NPC, 32'h0000_0FF2);
      rchk(OFS_COUNT, 32'h0003_0004);
      rchk(OFS_FPSR, 32'h0E5A_3C11);
      rd(OFS_DSTAT, d, r);
      `CHK(d & 32'h10, 32'h10)
      run(32'hF241, 32'h0000, 32'h0, 32'h0E5A_3C11, 32'h0003_0000, 32'h3);
      rchk(OFS_NPC, 32'h0000_1006);
      rchk(OFS_COUNT, 32'h0003_FFFF);
      rd(OFS_DSTAT, d, r);
      `CHK(d & 32'h10, 32'h0)
      run(32'hF241, 32'h001F, 32'h0, 32'h0E5A_3C11, 32'h0003_0005, 32'h3);
      rchk(OFS_NPC, 32'h0000_1006);
      $display("test loop done");
    end
  endtask

  task automatic t_trap;
    logic [31:0] d;
    logic [1:0] r;
    begin
      run(32'hF241, 32'h0010, 32'h0, 32'h0100_0000, 32'h0003_0005, 32'h3);
      rchk(OFS_FPSR, 32'h0100_8080);
      rchk(OFS_COUNT, 32'h0003_0005);
      rchk(OFS_NPC, 32'h0000_1000);
      rd(OFS_DSTAT, d, r);
      `CHK(d & 32'h8, 32'h8)
      `CHK(traps, 1)
      run(32'hF241, 32'h0010, 32'h0, 32'h0100_8080, 32'h0003_0005, 32'h3);
      `CHK(traps, 2)
      run(32'hF241, 32'h0010, 32'h0, 32'h0100_0000, 32'h0003_0005, 32'h1);
      rchk(OFS_FPSR, 32'h0100_8080);
      rchk(OFS_COUNT, 32'h0003_0004);
      run(32'hF241, 32'h0010, 32'h0, 32'h0, 32'h0003_0005, 32'h3);
      rchk(OFS_FPSR, 32'h0000_0000);
      run(32'hF241, 32'h0000, 32'h0, 32'h0100_0000, 32'h0003_0005, 32'h3);
      rchk(OFS_FPSR, 32'h0100_0000);
      `CHK(traps, 2)
      $display("test trap done");
    end
  endtask

  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_cosh();
    t_refuse();
    t_loop();
    t_trap();
    close_out();
  end
endmodule
